/* File: rotc_regs.svh */
`ifndef ROTC_REGS_SVH
`define ROTC_REGS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define ROTC_CTRL_ADDR        8'hD7
`define ROTC_STATE_ADDR       8'hE9
`define ROTC_CTRL_RESET       8'h0E

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define ROTC_CTRL_XDIV_ON     7
`define ROTC_CTRL_XDIV_SEL    6
`define ROTC_CTRL_TRIM_MON    5
`define ROTC_CTRL_TRIM_HI     4
`define ROTC_CTRL_TRIM_LO     0

// ----------------------------------------------------------------------
// State field positions
// ----------------------------------------------------------------------
`define ROTC_STATE_RING_MON   7
`define ROTC_STATE_XTAL_MON   6
`define ROTC_STATE_XTAL_RUN   5

// ----------------------------------------------------------------------
// Divider ratios and clock figures
// ----------------------------------------------------------------------
`define ROTC_RING_DIV         256
`define ROTC_XTAL_MON_DIV     512
`define ROTC_RING_MHZ_X10     96
`define ROTC_CPU_MHZ_X10      24
`define ROTC_CPU_DIV          (`ROTC_RING_MHZ_X10 / `ROTC_CPU_MHZ_X10)

`endif

/* File: rotc_pkg.sv */
package rotc_pkg;
    typedef logic [4:0] rotc_trim_t;
    typedef enum logic [0:0] {
        ROTC_XSEL_DIV2,
        ROTC_XSEL_DIV32
    } rotc_xsel_e;
endpackage : rotc_pkg

/* File: rotc_divider.sv */
`timescale 1ns/1ps
`include "rotc_regs.svh"

// Free counter whose top bit toggles at clk/RATIO; holds when disabled.
// A clear restarts it from zero and wins over a count in the same cycle.
module rotc_divider #(
    parameter int RATIO = 2
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // Control
    input  wire logic enable_i,
    input  wire logic clear_i,
    // Output
    output logic      div_o
);
    localparam int W = (RATIO > 2) ? $clog2(RATIO) : 1;

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (enable_i) begin
            cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
        if (clear_i) begin
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign div_o = cnt_q[W-1];
endmodule : rotc_divider

/* File: rotc_trim_control.sv */
`timescale 1ns/1ps
`include "rotc_regs.svh"

// Functional notes
// [R1] Processor clock is ring clock divided to 2.4 MHz
// [R2] Five-bit trim code tunes ring around 9.6 MHz
// [R3] Divider enable gates 1/32 and 1/16 chain
// [R4] Select bit picks crystal /2 or /32
// [R5] Software sets /32 select only with enable
// [R6] Monitor enable exposes ring output divided by 256
// [R7] State bit 7 is ring /256, reset zero
// [R8] State bit 6 is crystal /512, reset zero
// [R9] Firmware calibrates trim against the crystal
// [R10] Crystal running flag reads oscillation state
// [R11] Monitor disabled freezes ring /256 counter
module rotc_trim_control (
    // Clocks and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             ring_clk_i,
    input  wire logic             xtal_clk_i,
    input  wire logic             xtal_running_i,
    input  wire logic             timer_reset_i,
    // Special function register port
    input  wire logic [7:0]       sfr_addr_i,
    input  wire logic             sfr_wr_i,
    input  wire logic             sfr_rd_i,
    input  wire logic [7:0]       sfr_wdata_i,
    output logic      [7:0]       sfr_rdata_o,
    // Oscillator controls
    output rotc_pkg::rotc_trim_t  ring_trim_code_o,
    output logic                  crystal_divider_on_o,
    output logic                  crystal_divide_choice_o,
    output logic                  trim_monitor_on_o,
    output logic                  cpu_clk_en_o,
    output logic                  xtal_clk_sel_o
);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Oscillator clocks are sampled as levels; the edge detectors below
    // look at the second and third stages.
    logic [2:0] ring_s_q, ring_s_d;
    logic [2:0] xtal_s_q, xtal_s_d;
    logic [1:0] run_s_q, run_s_d;

    always_comb begin
        ring_s_d = {ring_s_q[1:0], ring_clk_i};
        xtal_s_d = {xtal_s_q[1:0], xtal_clk_i};
        run_s_d  = {run_s_q[0], xtal_running_i};
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ring_s_q <= 3'h0;
            xtal_s_q <= 3'h0;
            run_s_q  <= 2'h0;
        end else begin
            ring_s_q <= ring_s_d;
            xtal_s_q <= xtal_s_d;
            run_s_q  <= run_s_d;
        end
    end

    logic ring_rise;
    logic xtal_rise;
    logic xtal_run;
    assign ring_rise = ring_s_q[1] & ~ring_s_q[2];
    assign xtal_rise = xtal_s_q[1] & ~xtal_s_q[2];
    // Running flag is a slow level, so two stages and no edge logic
    assign xtal_run  = run_s_q[1];

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [7:0] ctrl_q, ctrl_d;

    // Address match shared by the write and read decoders
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    always_comb begin
        ctrl_d = ctrl_q;
        if (sfr_wr_i && hit(sfr_addr_i, `ROTC_CTRL_ADDR)) begin
            ctrl_d = sfr_wdata_i;
        end
        // Timer reset clears the three mode bits, keeps the trim code
        if (timer_reset_i) begin
            ctrl_d[`ROTC_CTRL_XDIV_ON]  = 1'b0;
            ctrl_d[`ROTC_CTRL_XDIV_SEL] = 1'b0;
            ctrl_d[`ROTC_CTRL_TRIM_MON] = 1'b0;
        end
        // Divide-by-32 choice is only meaningful with the chain on
        // Refused rather than stored, so a read shows what the chain sees
        if (!ctrl_d[`ROTC_CTRL_XDIV_ON]) begin
            ctrl_d[`ROTC_CTRL_XDIV_SEL] = 1'b0; // [R5]
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_q <= `ROTC_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    logic xdiv_on;
    logic mon_on;
    assign xdiv_on = ctrl_q[`ROTC_CTRL_XDIV_ON];
    assign mon_on  = ctrl_q[`ROTC_CTRL_TRIM_MON];

    // ------------------------------------------------------------------
    // Ring monitor: /256 counter on clk_i, stepped by ring rising edges
    // ------------------------------------------------------------------
    logic ring_mon;
    logic ring_mon_clr;
    // Timer reset restarts the counter as well, so bit 7 reads 0
    assign ring_mon_clr = timer_reset_i;

    rotc_divider #(
        .RATIO (`ROTC_RING_DIV)
    ) u_ring_div (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .enable_i  (mon_on & ring_rise), // [R6] [R11]
        .clear_i   (ring_mon_clr),       // [R7]
        .div_o     (ring_mon)
    );

    // ------------------------------------------------------------------
    // Crystal /512 monitor, processor clock enable, crystal select
    // ------------------------------------------------------------------
    logic [8:0] xcnt_q, xcnt_d;
    logic [1:0] cdiv_q, cdiv_d;
    logic       cpu_en_q, cpu_en_d;
    logic       ring_bit_q, ring_bit_d;
    logic       xsel_q, xsel_d;

    always_comb begin
        xcnt_d     = xcnt_q;
        cdiv_d     = cdiv_q;
        cpu_en_d   = 1'b0;
        ring_bit_d = ring_mon;
        // Chain runs only when enabled
        if (xdiv_on && xtal_rise) begin
            xcnt_d = xcnt_q + 9'h001; // [R3]
        end
        // Processor clock is an enable pulse, not a second clock: one
        // domain, at the cost of a duty cycle of one system clock
        if (ring_rise) begin
            cdiv_d = cdiv_q + 2'h1;
            cpu_en_d = (cdiv_q == 2'(`ROTC_CPU_DIV - 1)); // [R1]
        end
        // Timer reset restarts both monitors from zero
        if (ring_mon_clr) begin
            xcnt_d     = 9'h000;
            ring_bit_d = 1'b0; // [R7]
        end
        xsel_d = (xdiv_on & ctrl_q[`ROTC_CTRL_XDIV_SEL])
               ? 1'(rotc_pkg::ROTC_XSEL_DIV32)
               : 1'(rotc_pkg::ROTC_XSEL_DIV2); // [R4]
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            xcnt_q     <= 9'h000;
            cdiv_q     <= 2'h0;
            cpu_en_q   <= 1'b0;
            ring_bit_q <= 1'b0;
            xsel_q     <= 1'b0;
        end else begin
            xcnt_q     <= xcnt_d;
            cdiv_q     <= cdiv_d;
            cpu_en_q   <= cpu_en_d;
            ring_bit_q <= ring_bit_d;
            xsel_q     <= xsel_d;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Read data stands one cycle, then falls back to zero
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] state_v;

    always_comb begin
        state_v = 8'h00;
        state_v[`ROTC_STATE_RING_MON] = ring_bit_q; // [R7]
        state_v[`ROTC_STATE_XTAL_MON] = xcnt_q[8];  // [R8]
        state_v[`ROTC_STATE_XTAL_RUN] = xtal_run;   // [R10]
        rdata_d = 8'h00;
        if (sfr_rd_i && hit(sfr_addr_i, `ROTC_CTRL_ADDR)) begin
            rdata_d = ctrl_q;
        end else if (sfr_rd_i && hit(sfr_addr_i, `ROTC_STATE_ADDR)) begin
            rdata_d = state_v;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Trim code goes straight to the analog resistor ladder
    assign ring_trim_code_o        =
        ctrl_q[`ROTC_CTRL_TRIM_HI:`ROTC_CTRL_TRIM_LO]; // [R2]
    assign crystal_divider_on_o    = ctrl_q[`ROTC_CTRL_XDIV_ON];
    assign crystal_divide_choice_o = ctrl_q[`ROTC_CTRL_XDIV_SEL];
    assign trim_monitor_on_o       = ctrl_q[`ROTC_CTRL_TRIM_MON];
    assign cpu_clk_en_o            = cpu_en_q;
    assign xtal_clk_sel_o          = xsel_q;
    assign sfr_rdata_o             = rdata_q;
endmodule : rotc_trim_control

/* File: rotc_checker_assertions.sv */
`timescale 1ns/1ps
module rotc_checker (
    // Clock, reset and inputs
    input wire logic                 clk_i,
    input wire logic                 reset_n_i,
    input wire logic                 timer_reset_i,
    input wire logic                 xtal_running_i,
    input wire logic [7:0]           sfr_addr_i,
    input wire logic                 sfr_wr_i,
    input wire logic                 sfr_rd_i,
    input wire logic [7:0]           sfr_wdata_i,
    // Outputs of the block
    input wire logic [7:0]           sfr_rdata_o,
    input wire rotc_pkg::rotc_trim_t ring_trim_code_o,
    input wire logic                 crystal_divider_on_o,
    input wire logic                 crystal_divide_choice_o,
    input wire logic                 trim_monitor_on_o,
    input wire logic                 cpu_clk_en_o,
    input wire logic                 xtal_clk_sel_o
);
    wire wr_c = sfr_wr_i && sfr_addr_i == 8'hD7;
    wire rd_c = sfr_rd_i && sfr_addr_i == 8'hD7;
    wire rd_s = sfr_rd_i && sfr_addr_i == 8'hE9;
    wire tr_c = timer_reset_i && !sfr_wr_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_trim_write: assert property (wr_c |=>
        ring_trim_code_o == $past(sfr_wdata_i[4:0])) else $error("trim");
    a_sel_needs_on: assert property (crystal_divide_choice_o |->
        crystal_divider_on_o) else $error("select without enable");
    a_xsel_follow: assert property (xtal_clk_sel_o == $past(
        crystal_divider_on_o && crystal_divide_choice_o)) else $error("sel");
    a_cpu_spacing: assert property (cpu_clk_en_o |=>
        !cpu_clk_en_o [*7]) else $error("cpu enable spacing");
    a_ctrl_read: assert property (rd_c |=> sfr_rdata_o == $past({
        crystal_divider_on_o, crystal_divide_choice_o, trim_monitor_on_o,
        ring_trim_code_o})) else $error("control readback");
    a_timer_clear: assert property (tr_c |=> !crystal_divider_on_o
        && !trim_monitor_on_o) else $error("timer reset clear");
    a_timer_keep: assert property (tr_c |=>
        $stable(ring_trim_code_o)) else $error("timer reset trim");
    a_run_flag: assert property ($stable(xtal_running_i) [*4] ##0 rd_s
        |=> sfr_rdata_o[5] == $past(xtal_running_i)) else $error("run flag");
endmodule : rotc_checker

bind rotc_trim_control rotc_checker u_rotc_checker (.clk_i, .reset_n_i,
    .timer_reset_i, .xtal_running_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
    .sfr_wdata_i, .sfr_rdata_o, .ring_trim_code_o, .crystal_divider_on_o,
    .crystal_divide_choice_o, .trim_monitor_on_o, .cpu_clk_en_o,
    .xtal_clk_sel_o);

/* File: ring_oscillator_trim_control_tb_top.sv */
`timescale 1ns/1ps
module ring_oscillator_trim_control_tb_top;
    logic                 clk_i = 0, reset_n_i = 0, ring_clk_i = 0;
    logic                 xtal_clk_i = 0, xtal_running_i = 1;
    logic                 timer_reset_i = 0, sfr_wr_i = 0, sfr_rd_i = 0;
    logic [7:0]           sfr_addr_i = 0, sfr_wdata_i = 0, sfr_rdata_o, d;
    rotc_pkg::rotc_trim_t ring_trim_code_o;
    logic                 crystal_divider_on_o, crystal_divide_choice_o;
    logic                 trim_monitor_on_o, cpu_clk_en_o, xtal_clk_sel_o;
    logic                 rd_q = 0;
    logic [15:0]          e, exp_q[$];
    int                   n_fail = 0, num_checks = 0, seed = 485;
    int                   ph = 0, np;

    always #5 clk_i = ~clk_i;

    rotc_trim_control u_rotc_trim_control (.clk_i, .reset_n_i, .ring_clk_i,
        .xtal_clk_i, .xtal_running_i, .timer_reset_i, .sfr_addr_i,
        .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .ring_trim_code_o,
        .crystal_divider_on_o, .crystal_divide_choice_o,
        .trim_monitor_on_o, .cpu_clk_en_o, .xtal_clk_sel_o);

    // Ring near 10 MHz; crystal slower than clk/4 as the inputs require
    always @(negedge clk_i) begin
        ph <= ph + 1;
        if (ph % 5 == 4) ring_clk_i <= ~ring_clk_i;
        if (ph % 3 == 2) xtal_clk_i <= ~xtal_clk_i;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        sfr_addr_i = a;
        sfr_wdata_i = v;
        sfr_wr_i = 1;
        cyc(1);
        sfr_wr_i = 0;
    endtask : wr

    // Mask in the upper byte: monitor bits are only known in part
    task automatic rd(input logic [7:0] a, m, x);
        sfr_addr_i = a;
        sfr_rd_i = 1;
        exp_q.push_back({m, x});
        cyc(1);
        sfr_rd_i = 0;
        cyc(1);
    endtask : rd

    // ------------------------------------------------------------------
    // Read data watcher
    // ------------------------------------------------------------------
    always @(posedge clk_i) rd_q <= sfr_rd_i;
    always @(negedge clk_i) begin
        if (rd_q) begin
            e = exp_q.pop_front();
            chk(sfr_rdata_o & e[15:8], e[7:0]);
        end
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        cyc(20);
        reset_n_i = 1;
        cyc(1);
        rd(8'hD7, 8'hFF, 8'h0E);
        wr(8'hE9, 8'hFF);
        rd(8'hE9, 8'hFF, 8'h20);
        repeat (8) begin
            d = 8'($random(seed));
            wr(8'hD7, d);
            rd(8'hD7, 8'hFF, d & (d[7] ? 8'hFF : 8'hBF));
        end
        wr(8'hD7, 8'h20);
        cyc(1400);
        rd(8'hE9, 8'h80, 8'h80);
        wr(8'hD7, 8'hCB);
        cyc(1300);
        chk({7'h00, xtal_clk_sel_o}, 8'h01);
        chk({3'h0, ring_trim_code_o}, 8'h0B);
        rd(8'hE9, 8'h80, 8'h80);
        timer_reset_i = 1;
        cyc(1);
        timer_reset_i = 0;
        rd(8'hE9, 8'hC0, 8'h00);
        rd(8'hD7, 8'hFF, 8'h0B);
        wr(8'hD7, 8'h80);
        cyc(2000);
        chk({crystal_divider_on_o, crystal_divide_choice_o,
            trim_monitor_on_o, ring_trim_code_o}, 8'h80);
        chk({7'h00, xtal_clk_sel_o}, 8'h00);
        rd(8'hE9, 8'h40, 8'h40);
        np = 0;
        repeat (400) begin
            cyc(1);
            np += int'(cpu_clk_en_o);
        end
        chk(8'(np >= 9 && np <= 11), 8'h01);
        xtal_running_i = 0;
        cyc(6);
        rd(8'hE9, 8'h20, 8'h00);
        cyc(2);
        chk(8'(exp_q.size()), 8'h00);
        give_verdict();
    end
endmodule : ring_oscillator_trim_control_tb_top
